// ### rtl/tpc_capture.sv
// capture trigger selection, edge detection and capture-clock sampling
`timescale 1ns/100ps
module tpc_capture #(
  parameter bit TRIG3_TIMER = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cap_tick,
  input wire logic [1:0] trig_sel,
  input wire logic edge_spec,
  input wire logic edge_pol,
  input wire logic ext_ena,
  input wire logic timer_sel,
  input wire logic [3:0] ext_irq,
  input wire logic timer0_irq,
  input wire logic timer1_irq,
  input wire logic sw_write,
  output logic load,
  output logic load_hw
);
  logic use_timer;
  logic src;
  logic lvl_reg;
  logic rise;
  logic fall;
  logic hw_edge;
  logic sw_pend_reg;
  logic hw_samp_reg;
  logic sw_samp_reg;

  assign use_timer = TRIG3_TIMER && (trig_sel == tpc_pkg::TRIG_SEL_LAST);
  assign src = use_timer ? (timer_sel ? timer1_irq : timer0_irq) : ext_irq[trig_sel]; // RULE9
  assign rise = src && !lvl_reg;
  assign fall = !src && lvl_reg;
  // timer interrupt ignores the edge choice
  assign hw_edge = use_timer ? rise : // RULE19
                   (edge_spec ? (edge_pol ? rise : fall) : (rise || fall)); // RULE10

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_reg <= 1'b0;
    end else if (cap_tick) begin
      lvl_reg <= src; // RULE12
    end
  end

  // a write can land between capture-clock edges, so it waits here; a new write wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_pend_reg <= 1'b0;
    end else if (sw_write) begin
      sw_pend_reg <= 1'b1; // RULE17
    end else if (cap_tick) begin
      sw_pend_reg <= 1'b0;
    end
  end

  // first capture edge samples the trigger, the second loads at the pulse's falling edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hw_samp_reg <= 1'b0;
      sw_samp_reg <= 1'b0;
    end else if (cap_tick) begin
      hw_samp_reg <= ext_ena && hw_edge; // RULE16
      // only the pending flag is sampled: taking the write strobe too captured twice
      sw_samp_reg <= sw_pend_reg; // RULE18
    end
  end

  assign load = cap_tick && (hw_samp_reg || sw_samp_reg); // RULE12 RULE14
  assign load_hw = cap_tick && hw_samp_reg;
endmodule : tpc_capture

// ### rtl/tpc_clk_div.sv
// count clock selection and prescaler producing one-cycle enables
`timescale 1ns/100ps
module tpc_clk_div (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic slow_tick,
  input wire logic [1:0] src_sel,
  input wire logic [1:0] prescale_sel,
  output logic tick
);
  logic base;
  logic [2:0] div_reg;
  logic [2:0] mask;

  // high-speed and system clock both run at aclk here; other sources use the slow enable
  assign base = (src_sel == tpc_pkg::SRC_HIGH_SPEED || src_sel == tpc_pkg::SRC_SYSTEM) ?
                1'b1 : slow_tick;
  assign mask = 3'((4'h1 << prescale_sel) - 4'h1);
  assign tick = base && ((div_reg & mask) == mask);

  // divider restarts while stopped so the first period after enable is full length
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      div_reg <= 3'h0;
    end else if (base) begin
      div_reg <= div_reg + 3'h1;
    end
  end
endmodule : tpc_clk_div

// ### rtl/tpc_pkg.sv
// shared constants of the period/duty pwm and capture timer
package tpc_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PERIOD_PRESET_OFS = 8'h04;
  localparam logic [7:0] DUTY_PRESET_OFS = 8'h08;
  localparam logic [7:0] CAPTURE_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  // control register fields
  localparam int COUNT_EN_BIT = 0;
  localparam int PWM_MODE_BIT = 1;
  localparam int CLEAR_SEL_BIT = 2;
  localparam int PWM_RESET_SEL_BIT = 3;
  localparam int CLK_SRC_LSB = 4;
  localparam int PRESCALE_LSB = 6;
  localparam int CAP_CLK_SEL_BIT = 8;
  localparam int TRIG_SEL_LSB = 9;
  localparam int EDGE_SPEC_BIT = 11;
  localparam int EDGE_POL_BIT = 12;
  localparam int EXT_CAP_EN_BIT = 13;
  localparam int CLR_ON_CAP_BIT = 14;
  localparam int TIMER_IRQ_SEL_BIT = 15;
  localparam logic [31:0] CTRL_MASK = 32'h0000FFFF;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  // status register fields
  localparam int STATUS_PWM_BIT = 16;
  // count clock sources and the last trigger select value
  localparam logic [1:0] SRC_HIGH_SPEED = 2'h0;
  localparam logic [1:0] SRC_SYSTEM = 2'h1;
  localparam logic [1:0] TRIG_SEL_LAST = 2'h3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tpc_pkg

// ### rtl/tpc_top.sv
// timer channel: period/duty pwm generator and input capture behind an axi4-lite slave
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RULE1 - in pwm mode period compare sets the period, duty compare the high time
// RULE2 - output is high while the counter runs from zero up to duty compare
// RULE3 - duty match drops output low; counter runs on until period match clears it
// RULE4 - the period match clear drives the output high again
// RULE5 - while count enable is zero the pwm output holds high
// RULE6 - software sets clear select and reset select to one for this mode
// RULE7 - output is low after reset and goes high when pwm mode is selected
// RULE8 - duty compare at or above period compare keeps the output high
// RULE9 - capture on external interrupt, timer 0/1 interrupt or software write
// RULE10 - trigger select picks interrupt line; edge bits pick both, falling or rising
// RULE11 - software keeps capture clock select zero for high-speed or system sources
// RULE12 - triggers sampled on capture clock; load on the second capture clock edge
// RULE13 - software spaces triggers more than two capture clocks apart
// RULE14 - stored value is the counter at the falling edge of the synced trigger
// RULE15 - each capture overwrites the capture register, read or not
// RULE16 - external capture is off after reset until its enable bit is written one
// RULE17 - any write to the capture register triggers a synchronized capture
// RULE18 - software capture works regardless of the external capture enable
// RULE19 - trigger select three picks timer 0/1 interrupt and ignores edge choice
// RULE20 - clear on capture clears the counter on hardware capture while counting; here it does so only when TRIG3_TIMER is set
// RULE21 - software uses all ones period or overflow clear for a free-running counter
// RULE22 - presets move to compares with the count clock; stopping clears the counter
// RULE23 - reading the capture register returns the last capture without side effects
module tpc_top #(
  parameter int ADDR_W = 8,
  parameter int CNT_W = 16,
  parameter bit TRIG3_TIMER = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] ext_irq,
  input wire logic timer0_irq,
  input wire logic timer1_irq,
  input wire logic slow_tick,
  output logic timer_output_pin
);
  if (CNT_W < 2 || CNT_W > 32) begin : g_cnt_w_check
    $error("tpc_top: CNT_W must lie in 2..32");
  end
  if (ADDR_W < 5 || ADDR_W > 32) begin : g_addr_w_check
    $error("tpc_top: ADDR_W must lie in 5..32");
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////////
  // registers and bus state
  logic [31:0] ctrl_reg;
  logic [31:0] period_preset_reg;
  logic [31:0] duty_preset_reg;
  logic [CNT_W-1:0] period_compare_reg;
  logic [CNT_W-1:0] duty_compare_reg;
  logic [CNT_W-1:0] binary_counter_reg;
  logic [CNT_W-1:0] capture_register_reg;
  logic pwm_reg;
  logic pwm_mode_q_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic aw_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_full_reg;
  logic wr_go;
  logic [7:0] wr_ofs;
  logic wr_hit;
  logic [7:0] rd_ofs;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic sw_capture;

  logic count_enable_bit;
  logic pwm_mode_select;
  logic counter_clear_select;
  logic pwm_reset_select;
  logic capture_clock_select;
  logic clear_on_capture;
  logic cnt_tick;
  logic cap_tick;
  logic cap_load;
  logic cap_load_hw;
  logic period_hit;
  logic wrap_hit;
  logic reset_hit;
  logic duty_ge_period;

  assign count_enable_bit = ctrl_reg[tpc_pkg::COUNT_EN_BIT];
  assign pwm_mode_select = ctrl_reg[tpc_pkg::PWM_MODE_BIT];
  assign counter_clear_select = ctrl_reg[tpc_pkg::CLEAR_SEL_BIT];
  assign pwm_reset_select = ctrl_reg[tpc_pkg::PWM_RESET_SEL_BIT];
  assign capture_clock_select = ctrl_reg[tpc_pkg::CAP_CLK_SEL_BIT];
  assign clear_on_capture = ctrl_reg[tpc_pkg::CLR_ON_CAP_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data accepted in either order
  assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign wr_ofs = 8'(aw_addr_reg);
  assign wr_hit = (aw_addr_reg >> 8) == '0 && (wr_ofs == tpc_pkg::CTRL_OFS ||
                  wr_ofs == tpc_pkg::PERIOD_PRESET_OFS || wr_ofs == tpc_pkg::DUTY_PRESET_OFS ||
                  wr_ofs == tpc_pkg::CAPTURE_OFS || wr_ofs == tpc_pkg::STATUS_OFS);
  assign sw_capture = wr_go && wr_hit && wr_ofs == tpc_pkg::CAPTURE_OFS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      aw_full_reg <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      w_full_reg <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tpc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? tpc_pkg::RESP_OKAY : tpc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control bits reset to zero, which leaves external capture disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= tpc_pkg::CTRL_RESET; // RULE16
    end else if (wr_go && wr_hit && wr_ofs == tpc_pkg::CTRL_OFS) begin
      ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) & tpc_pkg::CTRL_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_preset_reg <= 32'h00000000;
      duty_preset_reg <= 32'h00000000;
    end else if (wr_go && wr_hit) begin
      if (wr_ofs == tpc_pkg::PERIOD_PRESET_OFS) begin
        period_preset_reg <= merge(period_preset_reg, w_data_reg, w_strb_reg);
      end
      if (wr_ofs == tpc_pkg::DUTY_PRESET_OFS) begin
        duty_preset_reg <= merge(duty_preset_reg, w_data_reg, w_strb_reg);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel
  assign rd_ofs = 8'(s_axi_araddr);

  always_comb begin
    rd_hit = (s_axi_araddr >> 8) == '0;
    rd_mux = 32'h00000000;
    unique case (rd_ofs)
      tpc_pkg::CTRL_OFS: rd_mux = ctrl_reg;
      tpc_pkg::PERIOD_PRESET_OFS: rd_mux = period_preset_reg;
      tpc_pkg::DUTY_PRESET_OFS: rd_mux = duty_preset_reg;
      tpc_pkg::CAPTURE_OFS: rd_mux = 32'(capture_register_reg); // RULE23
      tpc_pkg::STATUS_OFS: begin
        rd_mux = 32'(binary_counter_reg);
        rd_mux[tpc_pkg::STATUS_PWM_BIT] = pwm_reg;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= tpc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_hit ? rd_mux : 32'h00000000;
      s_axi_rresp <= rd_hit ? tpc_pkg::RESP_OKAY : tpc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // count clock and capture clock
  tpc_clk_div u_clk_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(count_enable_bit),
    .slow_tick(slow_tick),
    .src_sel(ctrl_reg[tpc_pkg::CLK_SRC_LSB +: 2]),
    .prescale_sel(ctrl_reg[tpc_pkg::PRESCALE_LSB +: 2]),
    .tick(cnt_tick)
  );

  // system-clock sampling runs every cycle; otherwise capture follows the count clock
  assign cap_tick = capture_clock_select || cnt_tick; // RULE11

  tpc_capture #(
    .TRIG3_TIMER(TRIG3_TIMER)
  ) u_capture (
    .aclk(aclk),
    .aresetn(aresetn),
    .cap_tick(cap_tick),
    .trig_sel(ctrl_reg[tpc_pkg::TRIG_SEL_LSB +: 2]),
    .edge_spec(ctrl_reg[tpc_pkg::EDGE_SPEC_BIT]),
    .edge_pol(ctrl_reg[tpc_pkg::EDGE_POL_BIT]),
    .ext_ena(ctrl_reg[tpc_pkg::EXT_CAP_EN_BIT]),
    .timer_sel(ctrl_reg[tpc_pkg::TIMER_IRQ_SEL_BIT]),
    .ext_irq(ext_irq),
    .timer0_irq(timer0_irq),
    .timer1_irq(timer1_irq),
    .sw_write(sw_capture),
    .load(cap_load),
    .load_hw(cap_load_hw)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // compare registers and binary counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_compare_reg <= '0;
      duty_compare_reg <= '0;
    end else if (cnt_tick || !count_enable_bit) begin
      period_compare_reg <= period_preset_reg[CNT_W-1:0]; // RULE22
      duty_compare_reg <= duty_preset_reg[CNT_W-1:0];
    end
  end

  assign period_hit = counter_clear_select && binary_counter_reg == period_compare_reg; // RULE1
  assign wrap_hit = !counter_clear_select && binary_counter_reg == '1;
  assign reset_hit = pwm_reset_select ? binary_counter_reg == duty_compare_reg :
                     binary_counter_reg == period_compare_reg;
  assign duty_ge_period = duty_compare_reg >= period_compare_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      binary_counter_reg <= '0;
    end else if (!count_enable_bit) begin
      binary_counter_reg <= '0; // RULE22
    end else if (TRIG3_TIMER && clear_on_capture && cap_load_hw) begin
      binary_counter_reg <= '0; // RULE20
    end else if (cnt_tick) begin
      // full-count overflow wraps through zero by itself
      binary_counter_reg <= period_hit ? '0 : binary_counter_reg + 1'b1; // RULE3
    end
  end

  // every capture overwrites, no read-before-overwrite protection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_register_reg <= '0;
    end else if (cap_load) begin
      capture_register_reg <= binary_counter_reg; // RULE14 RULE15
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pwm output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_mode_q_reg <= 1'b0;
    end else begin
      pwm_mode_q_reg <= pwm_mode_select;
    end
  end

  // pulse and other output modes are not built here, so the pin idles low outside pwm mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_reg <= 1'b0; // RULE7
    end else if (!pwm_mode_select) begin
      pwm_reg <= 1'b0;
    end else if (!pwm_mode_q_reg) begin
      pwm_reg <= 1'b1; // RULE7
    end else if (!count_enable_bit) begin
      pwm_reg <= 1'b1; // RULE5
    end else if (duty_ge_period) begin
      pwm_reg <= 1'b1; // RULE8
    end else if (cnt_tick) begin
      if (period_hit || wrap_hit) begin
        pwm_reg <= 1'b1; // RULE4
      end else if (reset_hit) begin
        pwm_reg <= 1'b0; // RULE2 RULE3
      end
    end
  end

  assign timer_output_pin = pwm_reg;
endmodule : tpc_top

// ### sim/timer_pwm_period_duty_capture_test.sv
// self-checking bench for the period/duty pwm and capture timer
`timescale 1ns/100ps
module timer_pwm_period_duty_capture_test;
  localparam logic [31:0] EN = 32'h00000001 << tpc_pkg::COUNT_EN_BIT;
  localparam logic [31:0] PWM = (32'h00000001 << tpc_pkg::PWM_MODE_BIT) |
    (32'h00000001 << tpc_pkg::CLEAR_SEL_BIT) | (32'h00000001 << tpc_pkg::PWM_RESET_SEL_BIT);
  localparam logic [31:0] EXT = 32'h00000001 << tpc_pkg::EXT_CAP_EN_BIT;
  // per trigger case: edge specific, rising, capture on raise, capture on lower
  localparam logic [4:0] SPEC = 5'h1B;
  localparam logic [4:0] POLR = 5'h01;
  localparam logic [4:0] RCAP = 5'h1D;
  localparam logic [4:0] LCAP = 5'h06;
  typedef struct {logic [15:0] per; logic [15:0] duty; logic [15:0] hi; logic [15:0] lo;} tpc_row_s;
  tpc_row_s rows [5] = '{'{16'h0009, 16'h0003, 16'h0004, 16'h0006},
    '{16'h0004, 16'h0000, 16'h0001, 16'h0004}, '{16'h0005, 16'h0004, 16'h0005, 16'h0001},
    '{16'h0003, 16'h0003, 16'h0000, 16'h0000}, '{16'h0002, 16'h0007, 16'h0000, 16'h0000}};
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid, pin;
  logic t0, t1, ti0, ti1, clr;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, c1, cfg;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] lvl, irq;
  logic [15:0] hi_len, lo_len;
  int err_total, checks;
  tpc_top tpc_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .ext_irq(irq), .timer0_irq(ti0), .timer1_irq(ti1), .slow_tick(1'b0),
    .timer_output_pin(pin));
  tpc_irq_load tpc_irq_load_inst (.aclk(aclk), .lvl_req(lvl), .t0_req(t0), .t1_req(t1),
    .clr(clr), .pin(pin), .ext_irq(irq), .timer0_irq(ti0), .timer1_irq(ti1),
    .hi_len(hi_len), .lo_len(lo_len));
  initial aclk = 1'b0;
  always #5 aclk = ~aclk;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    @(posedge aclk);
    while (!bvalid) @(posedge aclk);
    resp = bresp;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    while (!rvalid) @(posedge aclk);
    rd = rdata;
    resp = rresp;
  endtask : rdr
  // generous bound: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    report_and_stop();
  end
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid, t0, t1, clr} = 6'h00;
    {awaddr, araddr, wdata, lvl} = 52'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(pin, 1'b0);
    rdr(tpc_pkg::CTRL_OFS);
    chk(rd, tpc_pkg::CTRL_RESET);
    rdr(8'h14);
    chk(rd, 32'h00000000);
    chk(resp, tpc_pkg::RESP_SLVERR);
    wr(8'h14, 32'hFFFFFFFF);
    chk(resp, tpc_pkg::RESP_SLVERR);
    foreach (rows[i]) begin
      wr(tpc_pkg::CTRL_OFS, PWM);
      repeat (2) @(posedge aclk);
      chk(pin, 1'b1);
      wr(tpc_pkg::PERIOD_PRESET_OFS, {16'h0000, rows[i].per});
      wr(tpc_pkg::DUTY_PRESET_OFS, {16'h0000, rows[i].duty});
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      wr(tpc_pkg::CTRL_OFS, PWM | EN);
      repeat (40) @(posedge aclk);
      chk(hi_len, rows[i].hi);
      chk(lo_len, rows[i].lo);
      if (rows[i].hi == 16'h0000) chk(pin, 1'b1);
    end
    wr(tpc_pkg::CTRL_OFS, PWM);
    rdr(tpc_pkg::STATUS_OFS);
    chk(rd[16:0], 17'h10000);
    // free run over the full range keeps later captures monotonic
    wr(tpc_pkg::CTRL_OFS, EN);
    repeat (20) @(posedge aclk);
    wr(tpc_pkg::CAPTURE_OFS, 32'h00000000);
    repeat (4) @(posedge aclk);
    rdr(tpc_pkg::CAPTURE_OFS);
    c1 = rd;
    chk(c1 != 32'h00000000, 1'b1);
    rdr(tpc_pkg::CAPTURE_OFS);
    chk(rd, c1);
    wr(tpc_pkg::CAPTURE_OFS, 32'h5A5A5A5A);
    repeat (4) @(posedge aclk);
    rdr(tpc_pkg::CAPTURE_OFS);
    chk(rd > c1, 1'b1);
    c1 = rd;
    lvl <= 4'hF;
    t0 <= 1'b1;
    repeat (6) @(posedge aclk);
    lvl <= 4'h0;
    t0 <= 1'b0;
    repeat (6) @(posedge aclk);
    rdr(tpc_pkg::CAPTURE_OFS);
    chk(rd, c1);
    for (int s = 0; s < 5; s++) begin
      cfg = EN | EXT | (32'(s > 3 ? 3 : s) << tpc_pkg::TRIG_SEL_LSB);
      cfg = cfg | (32'(SPEC[s]) << tpc_pkg::EDGE_SPEC_BIT) | (32'(POLR[s]) << tpc_pkg::EDGE_POL_BIT);
      wr(tpc_pkg::CTRL_OFS, cfg | (32'(s == 4) << tpc_pkg::TIMER_IRQ_SEL_BIT));
      rdr(tpc_pkg::CAPTURE_OFS);
      c1 = rd;
      if (s < 3) lvl[s] <= 1'b1;
      else if (s == 3) t0 <= 1'b1;
      else t1 <= 1'b1;
      repeat (6) @(posedge aclk);
      rdr(tpc_pkg::CAPTURE_OFS);
      chk(rd != c1, RCAP[s]);
      c1 = rd;
      lvl <= 4'h0;
      t0 <= 1'b0;
      t1 <= 1'b0;
      repeat (6) @(posedge aclk);
      rdr(tpc_pkg::CAPTURE_OFS);
      chk(rd != c1, LCAP[s]);
    end
    // prescale /2: two status reads two cycles apart see exactly one count
    wr(tpc_pkg::CTRL_OFS, EN | (32'h00000001 << tpc_pkg::PRESCALE_LSB));
    rdr(tpc_pkg::STATUS_OFS);
    c1 = rd;
    rdr(tpc_pkg::STATUS_OFS);
    chk(rd - c1, 32'h00000001);
    wr(tpc_pkg::CTRL_OFS, EN | EXT | (32'(SPEC[0]) << tpc_pkg::EDGE_SPEC_BIT) |
      (32'h00000001 << tpc_pkg::EDGE_POL_BIT) | (32'h00000001 << tpc_pkg::CLR_ON_CAP_BIT));
    repeat (50) @(posedge aclk);
    lvl[0] <= 1'b1;
    repeat (3) @(posedge aclk);
    rdr(tpc_pkg::STATUS_OFS);
    chk(rd[15:0] < 16'h0010, 1'b1);
    lvl <= 4'h0;
    report_and_stop();
  end
endmodule : timer_pwm_period_duty_capture_test
bind tpc_top tpc_top_sva #(.ADDR_W(ADDR_W)) tpc_top_sva_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .timer_output_pin(timer_output_pin));

// ### sim/tpc_irq_load.sv
// interrupt sources and pwm load facing the timer channel
`timescale 1ns/100ps
module tpc_irq_load (
  input wire logic aclk,
  input wire logic [3:0] lvl_req,
  input wire logic t0_req,
  input wire logic t1_req,
  input wire logic clr,
  input wire logic pin,
  output logic [3:0] ext_irq,
  output logic timer0_irq,
  output logic timer1_irq,
  output logic [15:0] hi_len,
  output logic [15:0] lo_len
);
  logic prev;
  logic [15:0] run;
  initial begin
    ext_irq = 4'h0;
    timer0_irq = 1'b0;
    timer1_irq = 1'b0;
    prev = 1'b0;
    run = 16'h0000;
  end
  // sources are registered so each trigger is a clean aclk-synchronous level
  always @(posedge aclk) begin
    ext_irq <= lvl_req;
    timer0_irq <= t0_req;
    timer1_irq <= t1_req;
  end
  // load measures the length of the last complete high and low phase
  always @(posedge aclk) begin
    prev <= pin;
    if (clr) begin
      hi_len <= 16'h0000;
      lo_len <= 16'h0000;
      run <= 16'h0001;
    end else if (pin != prev) begin
      if (pin) begin
        lo_len <= run;
      end else begin
        hi_len <= run;
      end
      run <= 16'h0001;
    end else begin
      run <= run + 16'h0001;
    end
  end
endmodule : tpc_irq_load

// ### sim/tpc_top_sva.sv
// port-level assertions for the timer channel
`timescale 1ns/100ps
module tpc_top_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_output_pin
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic mapped;
  assign mapped = s_axi_araddr inside {tpc_pkg::CTRL_OFS, tpc_pkg::PERIOD_PRESET_OFS,
    tpc_pkg::DUTY_PRESET_OFS, tpc_pkg::CAPTURE_OFS, tpc_pkg::STATUS_OFS};
  ////////////////////////////////////////
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    ##[1:3] s_axi_bvalid;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_ANSWER: assert property (wr_take |-> wr_answer)
    else $error("write response missing");
  AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_W_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  AST_RD_ANSWER: assert property (rd_take |=> s_axi_rvalid)
    else $error("read data late");
  AST_RD_UNMAPPED: assert property (rd_take and !mapped |=>
    s_axi_rresp == tpc_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  AST_RD_MAPPED: assert property (rd_take and mapped |=> s_axi_rresp == tpc_pkg::RESP_OKAY)
    else $error("mapped read refused");
  AST_PIN_RESET: assert property ($rose(aresetn) |-> !timer_output_pin)
    else $error("output not low after reset");
endmodule : tpc_top_sva
